/* failsafe_mode_supervisor_test.sv */
/*
  Bench for the supervisor: APB master, pin stimulus and host model.
  Assumes short watchdog counts set through the design parameters.
*/
`timescale 1ns/1ps
`include "fms_consts.vh"
module failsafe_mode_supervisor_test;
  localparam OD = 4;
  localparam WB = 64;
  reg c = 0, rst = 1, psel = 0, pen = 0, pw = 0, se;
  reg [7:0] pa = 0;
  reg [31:0] pd = 0, rd;
  reg wk = 0, ini = 0, da = 0, db = 0, ta = 0, tb = 0, sh = 0, oc = 0;
  reg of = 0, vok = 1;
  reg [1:0] fsp = 0;
  wire [31:0] prd;
  wire [7:0] rx;
  wire rdy, err, so, soe, sa, sb, ffo, ffoe, sck, sel, sdi;
  wire ffp = ffoe ? 1'b1 : ffo; // Open drain with a pull-up.
  integer err_count = 0, n_checks = 0, n;
  always #2.5 c = ~c;
  fms_supervisor #(.OSC_DIV(OD), .WD_BASE_TICKS(WB)) fms_supervisor_inst (
    .i_clk_sys(c), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .i_wake(wk), .i_init_n(ini),
    .i_failsafe_strap_pin(fsp), .i_direct_ctrl_a(da),
    .i_direct_ctrl_b(db), .i_thermal_a(ta), .i_thermal_b(tb),
    .i_supply_high(sh), .i_overcurrent(oc), .i_other_fault(of),
    .i_logic_supply_ok(vok), .i_serial_clk(sck), .i_serial_sel_n(sel),
    .i_serial_in(sdi), .o_serial_out(so), .o_serial_out_oe_n(soe),
    .o_switch_out_a(sa), .o_switch_out_b(sb), .o_fault_flag_n_out(ffo),
    .o_fault_flag_n_oe_n(ffoe));
  fms_host_model fms_host_model_inst (.i_so(so), .o_sclk(sck),
    .o_sel_n(sel), .o_sdi(sdi), .o_rx(rx));
  // ----
  // Shared tasks
  // ----
  task stop_test;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task eq(input [31:0] g, input [31:0] e, input [8*12:1] m);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0t %0s got %h", $time, m, g);
      end
    end
  endtask
  task wt(input integer k);
    repeat (k) @(posedge c);
  endtask
  // One APB transfer; request held until ready is seen high.
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge c);
      psel <= 1;
      pen <= 0;
      pw <= w;
      pa <= a;
      pd <= d;
      @(posedge c);
      pen <= 1;
      @(posedge c);
      while (rdy !== 1'b1)
        @(posedge c);
      rd = prd;
      se = err;
      psel <= 0;
      pen <= 0;
    end
  endtask
  task rck(input [7:0] a, input [31:0] m, input [31:0] e,
    input [8*12:1] s);
    begin
      apb(0, a, 0);
      eq(rd & m, e, s);
    end
  endtask
  // Polls the status word until fail-safe shows.
  task fs_wait;
    begin
      n = 0;
      rd = 0;
      while (rd[1:0] !== 2'h3 && n < 400)
      begin
        apb(0, `FMS_A_STAT, 0);
        n = n + 1;
      end
      eq(rd[1:0], 3, "fs reached");
    end
  endtask
  // ----
  // Scenarios
  // ----
  // Sleep after reset: settings read zero, writes refused, map checked.
  task t_sleep;
    begin
      rck(`FMS_A_STAT, 32'hf3f, 0, "sleep stat");
      apb(1, `FMS_A_CTRL, 32'h7ff);
      rck(`FMS_A_CTRL, 32'h7ff, 0, "sleep ctrl");
      eq({sa, sb, ffp}, 3'b001, "sleep pins");
      apb(1, `FMS_A_STAT, 32'hff);
      eq(se, 0, "stat wr err");
      rck(8'h08, 32'hffffffff, 0, "unmapped rd");
      eq(se, 1, "unmapped err");
    end
  endtask
  // Toggled keepalive holds Normal; silence then times out.
  task t_norm;
    integer k;
    begin
      @(posedge c) fsp <= `FMS_STRAP_BOTH;
      @(posedge c) ini <= 1;
      wt(4);
      apb(1, `FMS_A_CTRL, 32'h7e5);
      rck(`FMS_A_CTRL, 32'h7ff, 32'h7e5, "ctrl rw");
      rck(`FMS_A_STAT, 32'h3f, 32'h19, "normal");
      eq(ffp, 1, "normal flag");
      for (k = 0; k < 8; k = k + 1)
        fms_host_model_inst.xfer({~k[0], 7'h0});
      rck(`FMS_A_STAT, 32'h3, 1, "kept alive");
      n = 0;
      while (sb !== 1'b1 && n < 2000)
      begin
        @(posedge c);
        n = n + 1;
      end
      eq(n > WB * 2 * OD - 60 && n < WB * 2 * OD + 20, 1, "timeout len");
      rck(`FMS_A_STAT, 32'h37, 32'h37, "failsafe");
      rck(`FMS_A_CTRL, 32'h7ff, 32'h5, "fs ctrl");
      apb(1, `FMS_A_CTRL, 0);
      rck(`FMS_A_CTRL, 32'h7ff, 32'h5, "fs refused");
      @(posedge c) ini <= 0;
      wt(8);
      rck(`FMS_A_STAT, 32'h37, 0, "fs exit");
      rck(`FMS_A_CTRL, 32'h7ff, 0, "init clears");
    end
  endtask
  // Each non-ground strap code sets the fail-safe outputs over the direct inputs; ground keeps Normal.
  task t_strap;
    integer s;
    begin
      @(posedge c);
      da <= 1;
      db <= 1;
      for (s = 1; s < 4; s = s + 1)
      begin
        @(posedge c) fsp <= s;
        @(posedge c) wk <= 1;
        @(posedge c) ini <= 1;
        fs_wait;
        eq({sb, sa}, s == 3 ? 3 : s - 1, "strap outs");
        @(posedge c);
        if (s < 3)
        begin
          wk <= 0;
          ini <= 0;
        end
        else
          fsp <= 0;
        wt(8);
        rck(`FMS_A_STAT, 32'h7, s < 3 ? 0 : 1, "strap exit");
      end
      @(posedge c) ini <= 0;
      wt(8);
      @(posedge c) ini <= 1;
      wt(WB * OD * 3);
      rck(`FMS_A_STAT, 32'h7, 1, "grounded");
    end
  endtask
  // Loss of logic supply: registers reset, direct inputs drive.
  task t_vdd;
    begin
      apb(1, `FMS_A_CTRL, 32'h1);
      @(posedge c);
      da <= 0;
      vok <= 0;
      wt(8);
      eq({sb, sa}, 2'b10, "no supply");
      @(posedge c) vok <= 1;
      wt(8);
      rck(`FMS_A_CTRL, 32'h7ff, 0, "supply reset");
      @(posedge c) db <= 0;
    end
  endtask
  // Thermal and supply-high faults, fault byte and protect-off.
  task t_prot;
    begin
      apb(1, `FMS_A_CTRL, 32'h1);
      @(posedge c) tb <= 1;
      wt(8);
      rck(`FMS_A_STAT, 32'h100, 0, "off no therm");
      @(posedge c) tb <= 0;
      @(posedge c) ta <= 1;
      wt(8);
      rck(`FMS_A_STAT, 32'h113, 32'h102, "therm");
      eq(ffp, 0, "therm flag");
      @(posedge c) ta <= 0;
      wt(8);
      rck(`FMS_A_STAT, 32'h113, 32'h111, "retry");
      eq(ffp, 1, "flag back");
      fms_host_model_inst.xfer(0);
      eq(rx, 8'h01, "fault byte");
      fms_host_model_inst.xfer(0);
      eq(rx, 0, "byte cleared");
      @(posedge c) sh <= 1;
      wt(8);
      eq({ffp, sa}, 0, "supply high");
      @(posedge c) sh <= 0;
      wt(8);
      eq(sa, 1, "supply ok");
      fms_host_model_inst.xfer(0);
      eq(rx, 8'h02, "supply bit");
      apb(1, `FMS_A_CTRL, 32'h11);
      @(posedge c) sh <= 1;
      wt(8);
      eq({ffp, sa}, 2'b11, "protect off");
      rck(`FMS_A_STAT, 32'h200, 0, "no report");
      @(posedge c) sh <= 0;
    end
  endtask
  // Overcurrent holds the flag until commands drop; others release.
  task t_oc;
    begin
      @(posedge c) oc <= 1;
      wt(8);
      @(posedge c) oc <= 0;
      wt(8);
      eq(ffp, 0, "oc latched");
      apb(1, `FMS_A_CTRL, 0);
      wt(8);
      eq(ffp, 1, "oc released");
      @(posedge c) of <= 1;
      wt(8);
      eq(ffp, 0, "other fault");
      @(posedge c) of <= 0;
      wt(8);
      eq(ffp, 1, "other gone");
    end
  endtask
  // Main sequence after a twelve-cycle reset.
  initial
  begin
    repeat (12) @(posedge c);
    rst <= 0;
    t_sleep;
    t_norm;
    t_strap;
    t_vdd;
    t_prot;
    t_oc;
    stop_test;
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    #400000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule

/* fms_chk.sv */
/*
  Checker for the supervisor ports: APB answers, sleep, protection,
  fault flag and serial output enable.
  Assumes pin inputs reach the logic through two synchroniser flops.
*/
`timescale 1ns/1ps
`include "fms_consts.vh"
module fms_chk #(
  parameter OSC_DIV = 200,
  parameter WD_BASE_TICKS = 1024
) (
  input wire i_clk_sys, // Clock.
  input wire i_rst, // Reset.
  input wire i_psel, // Select.
  input wire i_penable, // Enable.
  input wire [7:0] i_paddr, // Address.
  input wire [31:0] o_prdata, // Read data.
  input wire o_pslverr, // Error.
  input wire i_wake, // Wake pin.
  input wire i_init_n, // Init pin.
  input wire i_direct_ctrl_a, // Direct a.
  input wire i_thermal_a, // Thermal a.
  input wire i_supply_high, // Supply high.
  input wire i_overcurrent, // Overcurrent.
  input wire i_other_fault, // Other fault.
  input wire i_logic_supply_ok, // Supply good.
  input wire i_serial_sel_n, // Select pin.
  input wire o_serial_out_oe_n, // Serial enable.
  input wire o_switch_out_a, // Output a.
  input wire o_switch_out_b, // Output b.
  input wire o_fault_flag_n_out, // Flag level.
  input wire o_fault_flag_n_oe_n // Flag enable.
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  property p_err;
    i_psel && i_penable |->
      o_pslverr == (i_paddr != `FMS_A_CTRL && i_paddr != `FMS_A_STAT);
  endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_zero;
    i_psel && i_penable && o_pslverr |-> o_prdata == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("unmapped data");
  property p_hold;
    (i_psel && !i_penable) ##1 (i_psel && i_penable) |=> $stable(o_prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_od;
    o_fault_flag_n_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("flag drives high");
  property p_sleep;
    (!i_wake && !i_init_n && i_logic_supply_ok) [*6] |->
      !o_switch_out_a && !o_switch_out_b && o_fault_flag_n_oe_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not quiet");
  property p_hot;
    i_thermal_a [*6] |-> !o_switch_out_a;
  endproperty
  a_hot: assert property (p_hot) else $error("hot output on");
  property p_flag;
    (i_other_fault && i_init_n && i_logic_supply_ok) [*6] |->
      !o_fault_flag_n_oe_n;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not low");
  property p_so_on;
    (!i_serial_sel_n && i_init_n && i_logic_supply_ok) [*6] |->
      !o_serial_out_oe_n;
  endproperty
  a_so_on: assert property (p_so_on) else $error("serial idle");
  property p_so_off;
    i_serial_sel_n [*6] |-> o_serial_out_oe_n;
  endproperty
  a_so_off: assert property (p_so_off) else $error("serial drives");
  property p_nvdd;
    (!i_logic_supply_ok && i_init_n && !i_thermal_a && !i_supply_high &&
      !i_overcurrent && $stable(i_direct_ctrl_a)) [*6] |->
      o_switch_out_a == i_direct_ctrl_a;
  endproperty
  a_nvdd: assert property (p_nvdd) else $error("direct lost");
  c_frame: cover property (!i_serial_sel_n [*8]);
  c_hot: cover property (i_thermal_a [*8]);
  c_unmap: cover property (i_psel && i_penable && o_pslverr);
endmodule
bind fms_supervisor fms_chk #(.OSC_DIV(OSC_DIV),
  .WD_BASE_TICKS(WD_BASE_TICKS)) fms_chk_inst (.i_clk_sys, .i_rst,
  .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pslverr, .i_wake,
  .i_init_n, .i_direct_ctrl_a, .i_thermal_a, .i_supply_high,
  .i_overcurrent, .i_other_fault, .i_logic_supply_ok, .i_serial_sel_n,
  .o_serial_out_oe_n, .o_switch_out_a, .o_switch_out_b,
  .o_fault_flag_n_out, .o_fault_flag_n_oe_n);

/* fms_consts.vh */
/*
  Constants shared by the fail-safe mode supervisor: register offsets,
  field positions, reset values, fault byte layout and timing figures.
  Assumes each user includes it by bare name.
*/
`ifndef FMS_CONSTS_VH
`define FMS_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------------
`define FMS_A_CTRL 8'h00
`define FMS_A_STAT 8'h04

// ----------------------------------------------------------------------
// Control register fields and values
// ----------------------------------------------------------------------
`define FMS_CTRL_W 11
`define FMS_CTRL_RST 11'h000
`define FMS_CTRL_OC_MASK 11'h7e0
`define FMS_C_ON_A 0
`define FMS_C_ON_B 1
`define FMS_C_TSEL_LO 2
`define FMS_C_TSEL_HI 3
`define FMS_C_PROT_OFF 4

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define FMS_S_MODE_LO 0
`define FMS_S_MODE_HI 1
`define FMS_S_TIMEOUT 2
`define FMS_S_ARMED 3
`define FMS_S_OUT_A 4
`define FMS_S_OUT_B 5
`define FMS_S_FLT_LO 8
`define FMS_S_FLT_HI 11

// ----------------------------------------------------------------------
// Fault byte layout, shifted out on the serial port
// ----------------------------------------------------------------------
`define FMS_F_THERM 0
`define FMS_F_SUPHI 1
`define FMS_F_OVERCUR 2
`define FMS_F_OTHER 3

// ----------------------------------------------------------------------
// Serial frame and strap codes
// ----------------------------------------------------------------------
`define FMS_FRAME_BITS 4'h8
`define FMS_KEEPALIVE_BIT 7
`define FMS_STRAP_GND 2'h0
`define FMS_STRAP_OFF 2'h1
`define FMS_STRAP_A 2'h2
`define FMS_STRAP_BOTH 2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FMS_CLK_PERIOD_NS 5
`define FMS_OSC_PERIOD_NS 1000
`define FMS_WD_BASE_TICKS 1024

`endif

/* fms_host_model.sv */
/*
  Host side of the serial link: eight-bit frames on a 48 ns clock.
  Assumes the bench calls xfer for one frame at a time.
*/
`timescale 1ns/1ps
module fms_host_model (
  input wire i_so, // Serial data from the device.
  output reg o_sclk, // Serial clock, idle low.
  output reg o_sel_n, // Select, active low.
  output reg o_sdi, // Serial data to the device.
  output reg [7:0] o_rx // Byte received in the last frame.
);
  integer i;
  // The clock stands still outside frames.
  initial
  begin
    o_sclk = 0;
    o_sel_n = 1;
    o_sdi = 0;
    o_rx = 0;
  end
  // Sends one frame MSB first; data settles while the clock is low.
  task xfer(input [7:0] tx);
    begin
      o_sel_n = 0;
      #100;
      for (i = 7; i >= 0; i = i - 1)
      begin
        o_sdi = tx[i];
        #24 o_rx[i] = i_so; // Taken just before the device moves it.
        o_sclk = 1;
        #24 o_sclk = 0;
      end
      #50 o_sel_n = 1;
      o_sdi = ~o_sdi; // A released line shows no stale bit.
      #100;
    end
  endtask
endmodule

/* fms_supervisor.v */
/*
  Fail-safe mode supervisor for a dual high-side switch: mode sequencing,
  keepalive watchdog, fault flag, thermal and supply-high protection,
  a minimal serial receiver and an APB register slave.
  Assumes all pin inputs are asynchronous to i_clk_sys and that the
  serial clock is much slower than i_clk_sys so its edges can be seen.
*/
// Our own choices: the register addresses and the APB interface to the registers.
// Operation
// - Sleep at power-up and when wake, init low
// - Sleep makes all settings read as zero
// - Normal when init high, no fault, no timeout
// - Fault mode: flag low, faulted outputs off
// - Arm watchdog on wake or init rising
// - Keepalive missing before timeout latches fail-safe
// - Timeout is oscillator ticks scaled by select
// - Fail-safe drives outputs from strap level
// - Fail-safe resets only overcurrent settings
// - Timeout flag reads one during fail-safe
// - Wake and init low, or strap grounded, exits
// - Grounded strap disables watchdog and fail-safe
// - Missing logic supply resets registers
// - Without logic supply direct inputs drive outputs
// - Any fault pulls fault flag low, except in sleep
// - Flag releases with fault, except overcurrent
// - Fault byte shifted out, cleared by transfer
// - Thermal check only while output on
// - Thermal shutdown retries, sets sticky bit
// - Supply high keeps outputs off meanwhile
// - Supply high sets fault bit position one
// - Protect-off setting suppresses supply high handling
// - Eight-bit frames, MSB first, rising clock sample
// - Init low resets configuration and fault bits
`timescale 1ns/1ps
`include "fms_consts.vh"

module fms_supervisor #(
  parameter OSC_DIV = `FMS_OSC_PERIOD_NS / `FMS_CLK_PERIOD_NS,
  parameter WD_BASE_TICKS = `FMS_WD_BASE_TICKS
) (
  input wire i_clk_sys, // System clock, 200 MHz.
  input wire i_rst, // Asynchronous reset, active high.
  input wire i_psel, // APB select.
  input wire i_penable, // APB enable.
  input wire i_pwrite, // APB write.
  input wire [7:0] i_paddr, // APB byte address.
  input wire [31:0] i_pwdata, // APB write data.
  output reg [31:0] o_prdata, // APB read data.
  output wire o_pready, // APB ready.
  output reg o_pslverr, // APB error on unmapped address.
  input wire i_wake, // Wake pin.
  input wire i_init_n, // Init pin, active low.
  input wire [1:0] i_failsafe_strap_pin, // Decoded strap resistor.
  input wire i_direct_ctrl_a, // Direct input for output a.
  input wire i_direct_ctrl_b, // Direct input for output b.
  input wire i_thermal_a, // Overtemperature sense a.
  input wire i_thermal_b, // Overtemperature sense b.
  input wire i_supply_high, // Supply overvoltage sense.
  input wire i_overcurrent, // Overcurrent event sense.
  input wire i_other_fault, // Open-load or undervoltage.
  input wire i_logic_supply_ok, // Logic supply in range.
  input wire i_serial_clk, // Serial clock pin.
  input wire i_serial_sel_n, // Serial select pin, active low.
  input wire i_serial_in, // Serial data in.
  output reg o_serial_out, // Serial data out.
  output reg o_serial_out_oe_n, // Serial out enable, low drives.
  output reg o_switch_out_a, // High-side output a.
  output reg o_switch_out_b, // High-side output b.
  output wire o_fault_flag_n_out, // Fault flag pin level, always 0.
  output reg o_fault_flag_n_oe_n // Fault flag enable, low pulls low.
);

  // --------------------------------------------------------------------
  // Modes and local widths
  // --------------------------------------------------------------------
  localparam MODE_SLEEP = 2'h0;
  localparam MODE_NORMAL = 2'h1;
  localparam MODE_FAULT = 2'h2;
  localparam MODE_FAILSAFE = 2'h3;
  localparam NSYNC = 15;
  localparam [15:0] WD_BASE = WD_BASE_TICKS;
  localparam [15:0] OSC_LAST = OSC_DIV - 1;

  // Combines a fault byte with new events; setting always wins.
  function [3:0] merge_faults;
    input [3:0] cur;
    input [3:0] clr;
    input [3:0] set;
    begin
      merge_faults = (cur & ~clr) | set;
    end
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  assign raw_in = {i_wake, i_init_n, i_failsafe_strap_pin,
                   i_direct_ctrl_a, i_direct_ctrl_b, i_thermal_a,
                   i_thermal_b, i_supply_high, i_overcurrent,
                   i_other_fault, i_logic_supply_ok, i_serial_clk,
                   i_serial_sel_n, i_serial_in};

  // Two flops per pin; select resets to its idle high level.
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
        begin
          sync_a[gi] <= (gi == 1);
          sync_b[gi] <= (gi == 1);
        end
        else
        begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire s_wake = sync_b[14];
  wire s_init_n = sync_b[13];
  wire [1:0] s_strap = sync_b[12:11];
  wire s_dir_a = sync_b[10];
  wire s_dir_b = sync_b[9];
  wire s_therm_a = sync_b[8];
  wire s_therm_b = sync_b[7];
  wire s_suphi = sync_b[6];
  wire s_ocur = sync_b[5];
  wire s_other = sync_b[4];
  wire s_vdd_ok = sync_b[3];
  wire s_sclk = sync_b[2];
  wire s_sel_n = sync_b[1];
  wire s_si = sync_b[0];

  // Previous samples for edge detection.
  reg p_wake;
  reg p_init_n;
  reg p_sclk;
  reg p_sel_n;
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      p_wake <= 1'b0;
      p_init_n <= 1'b0;
      p_sclk <= 1'b0;
      p_sel_n <= 1'b1;
    end
    else
    begin
      p_wake <= s_wake;
      p_init_n <= s_init_n;
      p_sclk <= s_sclk;
      p_sel_n <= s_sel_n;
    end
  end

  wire strap_gnd = (s_strap == `FMS_STRAP_GND);
  wire both_low = ~s_wake & ~s_init_n;
  wire arm_edge = (s_wake & ~p_wake) | (s_init_n & ~p_init_n);
  wire sclk_rise = s_sclk & ~p_sclk;
  wire sel_fall = ~s_sel_n & p_sel_n;
  wire sel_rise = s_sel_n & ~p_sel_n;
  // Registers are held at default while init is low or supply is out.
  wire cfg_clear = ~s_init_n | ~s_vdd_ok;

  // --------------------------------------------------------------------
  // Mode state, control register and serial receiver state
  // --------------------------------------------------------------------
  reg [1:0] mode;
  reg [`FMS_CTRL_W-1:0] ctrl;
  reg [3:0] faults;
  reg armed;
  reg failsafe;
  reg oc_hold;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  reg [3:0] rx_cnt;
  reg [3:0] tx_snap;
  reg last_keep;
  reg [15:0] osc_cnt;
  reg [15:0] wd_cnt;

  // Settings seen by the logic; sleep forces all of them to zero.
  wire [`FMS_CTRL_W-1:0] ctrl_eff =
    (mode == MODE_SLEEP) ? `FMS_CTRL_RST : ctrl;
  wire [1:0] tsel = ctrl_eff[`FMS_C_TSEL_HI:`FMS_C_TSEL_LO];
  wire prot_off = ctrl_eff[`FMS_C_PROT_OFF];

  // --------------------------------------------------------------------
  // Output command and protection
  // --------------------------------------------------------------------
  reg cmd_a;
  reg cmd_b;

  // Chooses the command source by mode and logic supply state.
  always @*
  begin
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    if (!s_vdd_ok)
    begin
      cmd_a = s_dir_a;
      cmd_b = s_dir_b;
    end
    else if (mode == MODE_FAILSAFE)
    begin
      cmd_a = (s_strap == `FMS_STRAP_A) |
              (s_strap == `FMS_STRAP_BOTH);
      cmd_b = (s_strap == `FMS_STRAP_BOTH);
    end
    else if (mode != MODE_SLEEP)
    begin
      cmd_a = ctrl_eff[`FMS_C_ON_A] | s_dir_a;
      cmd_b = ctrl_eff[`FMS_C_ON_B] | s_dir_b;
    end
  end

  // Thermal sense counts only while its output is commanded on.
  wire hot_a = cmd_a & s_therm_a;
  wire hot_b = cmd_b & s_therm_b;
  wire suphi_act = s_suphi & ~prot_off;
  wire ocur_act = s_ocur | oc_hold;
  wire fault_now = hot_a | hot_b | suphi_act | ocur_act | s_other;

  wire [3:0] fault_set;
  assign fault_set[`FMS_F_THERM] = hot_a | hot_b;
  assign fault_set[`FMS_F_SUPHI] = suphi_act;
  assign fault_set[`FMS_F_OVERCUR] = s_ocur;
  assign fault_set[`FMS_F_OTHER] = s_other;

  // --------------------------------------------------------------------
  // Watchdog timing
  // --------------------------------------------------------------------
  wire osc_tick = (osc_cnt == OSC_LAST);
  wire [15:0] wd_limit = WD_BASE << tsel;
  wire wd_run = armed & ~strap_gnd & ~failsafe & (mode != MODE_SLEEP);
  wire frame_done = sel_rise & (rx_cnt == `FMS_FRAME_BITS);
  wire keep_now = rx_sh[`FMS_KEEPALIVE_BIT];
  wire keep_toggle = frame_done & (keep_now != last_keep);
  wire wd_expire = wd_run & osc_tick & (wd_cnt >= wd_limit - 16'h0001);

  // Internal oscillator model: one enable pulse per oscillator period.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      osc_cnt <= 16'h0000;
    else if (osc_tick)
      osc_cnt <= 16'h0000;
    else
      osc_cnt <= osc_cnt + 16'h0001;
  end

  // Timeout counter restarts on every keepalive toggle.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      wd_cnt <= 16'h0000;
    else if (!wd_run || keep_toggle || arm_edge)
      wd_cnt <= 16'h0000;
    else if (osc_tick)
      wd_cnt <= wd_cnt + 16'h0001;
  end

  // --------------------------------------------------------------------
  // Mode sequencing
  // --------------------------------------------------------------------
  // Arming, fail-safe latch and overcurrent hold.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      armed <= 1'b0;
      failsafe <= 1'b0;
      oc_hold <= 1'b0;
    end
    else
    begin
      if (strap_gnd || both_low)
      begin
        armed <= 1'b0;
        failsafe <= 1'b0;
      end
      else
      begin
        if (arm_edge)
          armed <= 1'b1;
        if (wd_expire)
          failsafe <= 1'b1;
      end
      // Overcurrent holds the flag until both commands are off.
      if (s_ocur)
        oc_hold <= 1'b1;
      else if (!cmd_a && !cmd_b)
        oc_hold <= 1'b0;
    end
  end

  // Mode register follows pins, faults and the fail-safe latch.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      mode <= MODE_SLEEP;
    else
    begin
      case (mode)
        MODE_SLEEP, MODE_NORMAL, MODE_FAULT, MODE_FAILSAFE:
        begin
          if (both_low)
            mode <= MODE_SLEEP;
          else if (failsafe || wd_expire)
            mode <= MODE_FAILSAFE;
          else if (fault_now)
            mode <= MODE_FAULT;
          else
            mode <= MODE_NORMAL;
        end
        default:
          mode <= MODE_SLEEP;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Outputs to the power stage and fault flag
  // --------------------------------------------------------------------
  // Protection gates the command; supply high forces both off.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_switch_out_a <= 1'b0;
      o_switch_out_b <= 1'b0;
      o_fault_flag_n_oe_n <= 1'b1;
    end
    else
    begin
      o_switch_out_a <= cmd_a & ~hot_a & ~suphi_act & ~ocur_act;
      o_switch_out_b <= cmd_b & ~hot_b & ~suphi_act & ~ocur_act;
      o_fault_flag_n_oe_n <= ~(fault_now & (mode != MODE_SLEEP));
    end
  end

  assign o_fault_flag_n_out = 1'b0;

  // --------------------------------------------------------------------
  // Serial receiver and fault byte
  // --------------------------------------------------------------------
  // Samples data on rising serial clock, MSB first, eight bits a frame.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      rx_cnt <= 4'h0;
      tx_snap <= 4'h0;
      last_keep <= 1'b0;
      o_serial_out <= 1'b0;
      o_serial_out_oe_n <= 1'b1;
    end
    else
    begin
      o_serial_out_oe_n <= s_sel_n;
      if (sel_fall)
      begin
        rx_cnt <= 4'h0;
        tx_sh <= {4'h0, faults};
        tx_snap <= faults;
        o_serial_out <= 1'b0;
      end
      else if (sclk_rise && !s_sel_n)
      begin
        rx_sh <= {rx_sh[6:0], s_si};
        tx_sh <= {tx_sh[6:0], 1'b0};
        o_serial_out <= tx_sh[6];
        if (rx_cnt != 4'hf)
          rx_cnt <= rx_cnt + 4'h1;
      end
      if (frame_done)
        last_keep <= keep_now;
      if (!wd_run)
        last_keep <= 1'b0;
    end
  end

  // Sticky fault bits; a valid frame clears the bits it shipped.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      faults <= 4'h0;
    else if (cfg_clear)
      faults <= 4'h0;
    else if (frame_done)
      faults <= merge_faults(faults, tx_snap, fault_set);
    else
      faults <= merge_faults(faults, 4'h0, fault_set);
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr = i_psel & i_penable & i_pwrite;
  wire hit_ctrl = (i_paddr == `FMS_A_CTRL);
  wire hit_stat = (i_paddr == `FMS_A_STAT);
  wire [31:0] stat_word;

  assign o_pready = 1'b1;
  assign stat_word = {20'h00000, faults, 2'h0, o_switch_out_b,
                      o_switch_out_a, armed,
                      (mode == MODE_FAILSAFE), mode};

  // Control register; fail-safe entry resets overcurrent fields.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      ctrl <= `FMS_CTRL_RST;
    else if (cfg_clear)
      ctrl <= `FMS_CTRL_RST;
    else if (wd_expire)
      ctrl <= ctrl & ~`FMS_CTRL_OC_MASK;
    else if (apb_wr && hit_ctrl && mode != MODE_FAILSAFE)
      ctrl <= i_pwdata[`FMS_CTRL_W-1:0];
  end

  // Read data and error are captured in the setup cycle.
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      o_pslverr <= ~(hit_ctrl | hit_stat);
      if (hit_ctrl)
        o_prdata <= {21'h000000, ctrl_eff};
      else if (hit_stat)
        o_prdata <= stat_word;
      else
        o_prdata <= 32'h00000000;
    end
  end

endmodule
